// *** src/gpb_regs.svh ***
// Purpose: Register offsets, reset values and sizes of the pad bank
// Assumes: Word-aligned byte offsets on a 32-bit bus
// Notes:   Definitions only
`ifndef GPB_REGS_SVH
`define GPB_REGS_SVH

// ============================================================
// Sizes
`define GPB_NPIN 17
`define GPB_ADDR_W 8
`define GPB_FUNC_W 2

// ============================================================
// Register offsets
`define GPB_OUT_OFS 8'h00
`define GPB_OE_OFS 8'h04
`define GPB_IN_OFS 8'h08
`define GPB_PU_OFS 8'h0C
`define GPB_PD_OFS 8'h10
`define GPB_FUNC0_OFS 8'h14
`define GPB_FUNC1_OFS 8'h18
`define GPB_ITYPE_OFS 8'h1C
`define GPB_IPOL_OFS 8'h20
`define GPB_ISTAT_OFS 8'h24
`define GPB_IMASK_OFS 8'h28
`define GPB_HOLD_OFS 8'h2C
`define GPB_STATE_OFS 8'h30

// ============================================================
// Field positions and reset values
`define GPB_HOLD_EN_BIT 0
`define GPB_HOLD_SLEEP_BIT 1
`define GPB_STATE_HOLD_BIT 0
`define GPB_STATE_SLEEP_BIT 1
`define GPB_ZERO_RST 32'h0000_0000

`endif

// *** src/gpb_pkg.sv ***
// Purpose: Shared types of the pad bank
// Assumes: Nothing beyond the register header
// Notes:   Function codes are a 2-bit field per pin
package gpb_pkg;

    // ============================================================
    // Pin function select
    typedef enum logic [1:0] {
        FN_GPIO,
        FN_ALT1,
        FN_ALT2,
        FN_ALT3
    } gpb_func_t;

    // ============================================================
    // Bus slave phase
    typedef enum logic [1:0] {
        BUS_IDLE,
        BUS_WR,
        BUS_RD
    } gpb_bus_t;

endpackage : gpb_pkg

// *** src/gpb_sense_if.sv ***
// Purpose: Carries input levels, trigger hits and trigger setup
// Assumes: Both ends on clk_sys_i
// Notes:   hit is a per-pin level, high while the trigger condition holds
`timescale 1ns/1ps
`default_nettype none
interface gpb_sense_if #(
    parameter int NPIN = 17
);
    logic [NPIN-1:0] lvl;
    logic [NPIN-1:0] hit;
    logic [NPIN-1:0] edge_sel;
    logic [NPIN-1:0] pol;

    modport sense (input edge_sel, input pol, output lvl, output hit);
    modport core (output edge_sel, output pol, input lvl, input hit);
endinterface : gpb_sense_if
`default_nettype wire

// *** src/gpb_sense.sv ***
// Purpose: Synchronises pad inputs and detects edge or level triggers
// Assumes: Pad levels are asynchronous to clk_sys_i
// Notes:   First stage feeds only the second stage
`timescale 1ns/1ps
`default_nettype none
module gpb_sense
    import gpb_pkg::*;
#(
    parameter int NPIN = 17
) (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_i,
    // Pads
    input wire logic [NPIN-1:0] pad_in_i,
    // To core
    gpb_sense_if.sense sif
);

    typedef struct packed {
        logic [NPIN-1:0] s1;
        logic [NPIN-1:0] s2;
        logic [NPIN-1:0] s3;
        logic [NPIN-1:0] hit;
    } gpb_sense_st_t;

    gpb_sense_st_t r;
    gpb_sense_st_t n;

    // ============================================================
    // Next state
    always_comb begin
        n = r;
        n.s1 = pad_in_i;
        n.s2 = r.s1;
        n.s3 = r.s2;
        // Edge mode: new level equals polarity; level mode: level equals polarity
        n.hit = ~(r.s2 ^ sif.pol) & (~sif.edge_sel | (r.s2 ^ r.s3));
    end

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    assign sif.lvl = r.s2;
    assign sif.hit = r.hit;

endmodule : gpb_sense
`default_nettype wire

// *** src/gpb_bank.sv ***
// Purpose: General purpose pad bank with AHB-Lite registers and interrupt
// Assumes: Peripherals feeding alt_* run on clk_sys_i; pads are asynchronous
// Notes:   Reads take one wait state, writes none; response always OKAY
// Contract
// - Seventeen pins, each function chosen by register
// - Per-pin pull-up, pull-down or high impedance
// - Input level sampled into readable register
// - Per-pin interrupt on edge or on level
// - Non-inverting tristate pad with output enable
// - Pin routable to alternate peripheral functions
// - Hold pad state; output enables forced low asleep
// - Hold keeps undriven pad at last level
//
// Register access over AHB-Lite and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "gpb_regs.svh"
module gpb_bank
    import gpb_pkg::*;
#(
    parameter int NPIN = `GPB_NPIN
) (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_i,
    // AHB-Lite slave
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic [31:0] hrdata_o,
    output logic hreadyout_o,
    output logic hresp_o,
    // Alternate peripherals, three functions of NPIN bits each
    input wire logic [3*NPIN-1:0] alt_out_i,
    input wire logic [3*NPIN-1:0] alt_oe_i,
    // Power management
    input wire logic sleep_i,
    // Pads
    input wire logic [NPIN-1:0] pad_in_i,
    output logic [NPIN-1:0] pad_out_o,
    output logic [NPIN-1:0] pad_oe_o,
    output logic [NPIN-1:0] pull_up_o,
    output logic [NPIN-1:0] pull_dn_o,
    output logic [NPIN-1:0] keep_o,
    output logic [NPIN-1:0] pin_lvl_o,
    // Interrupt
    output logic irq_o
);

    typedef struct packed {
        logic [NPIN-1:0] out;
        logic [NPIN-1:0] oe;
        logic [NPIN-1:0] pu;
        logic [NPIN-1:0] pd;
        logic [2*NPIN-1:0] func;
        logic [NPIN-1:0] itype;
        logic [NPIN-1:0] ipol;
        logic [NPIN-1:0] istat;
        logic [NPIN-1:0] imask;
        logic hold_en;
        logic sleep_oe_low;
        logic [NPIN-1:0] lvl;
        logic [NPIN-1:0] pad_out;
        logic [NPIN-1:0] pad_oe;
        logic [NPIN-1:0] pull_up;
        logic [NPIN-1:0] pull_dn;
        logic [NPIN-1:0] keep;
        logic irq;
        gpb_bus_t bus;
        logic [`GPB_ADDR_W-1:0] addr;
        logic readyout;
        logic [31:0] rdata;
    } gpb_st_t;

    gpb_st_t r;
    gpb_st_t n;

    logic [NPIN-1:0] mux_out;
    logic [NPIN-1:0] mux_oe;
    logic [31:0] rd_val;
    logic [NPIN-1:0] stat_clr;
    logic [63:0] func_wide;

    gpb_sense_if #(.NPIN(NPIN)) sif ();

    // ============================================================
    // Input sampling and trigger detection
    gpb_sense #(
        .NPIN(NPIN)
    ) u_sense (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .pad_in_i(pad_in_i),
        .sif(sif)
    );

    assign sif.edge_sel = r.itype;
    assign sif.pol = r.ipol;

    // ============================================================
    // Per-pin function routing
    generate
        for (genvar g = 0; g < NPIN; g++) begin : g_pin
            gpb_func_t fsel;
            assign fsel = gpb_func_t'(r.func[2*g +: `GPB_FUNC_W]);
            always_comb begin
                case (fsel)
                    FN_ALT1: begin
                        mux_out[g] = alt_out_i[g];
                        mux_oe[g] = alt_oe_i[g];
                    end
                    FN_ALT2: begin
                        mux_out[g] = alt_out_i[NPIN+g];
                        mux_oe[g] = alt_oe_i[NPIN+g];
                    end
                    FN_ALT3: begin
                        mux_out[g] = alt_out_i[2*NPIN+g];
                        mux_oe[g] = alt_oe_i[2*NPIN+g];
                    end
                    default: begin
                        mux_out[g] = r.out[g];
                        mux_oe[g] = r.oe[g];
                    end
                endcase
            end
        end
    endgenerate

    // ============================================================
    // Read data selection
    always_comb begin
        func_wide = '0;
        func_wide[2*NPIN-1:0] = r.func;
        rd_val = '0;
        if (r.addr == `GPB_OUT_OFS) begin
            rd_val[NPIN-1:0] = r.out;
        end else if (r.addr == `GPB_OE_OFS) begin
            rd_val[NPIN-1:0] = r.oe;
        end else if (r.addr == `GPB_IN_OFS) begin
            rd_val[NPIN-1:0] = r.lvl;
        end else if (r.addr == `GPB_PU_OFS) begin
            rd_val[NPIN-1:0] = r.pu;
        end else if (r.addr == `GPB_PD_OFS) begin
            rd_val[NPIN-1:0] = r.pd;
        end else if (r.addr == `GPB_FUNC0_OFS) begin
            rd_val = func_wide[31:0];
        end else if (r.addr == `GPB_FUNC1_OFS) begin
            rd_val = func_wide[63:32];
        end else if (r.addr == `GPB_ITYPE_OFS) begin
            rd_val[NPIN-1:0] = r.itype;
        end else if (r.addr == `GPB_IPOL_OFS) begin
            rd_val[NPIN-1:0] = r.ipol;
        end else if (r.addr == `GPB_ISTAT_OFS) begin
            rd_val[NPIN-1:0] = r.istat;
        end else if (r.addr == `GPB_IMASK_OFS) begin
            rd_val[NPIN-1:0] = r.imask;
        end else if (r.addr == `GPB_HOLD_OFS) begin
            rd_val[`GPB_HOLD_EN_BIT] = r.hold_en;
            rd_val[`GPB_HOLD_SLEEP_BIT] = r.sleep_oe_low;
        end else if (r.addr == `GPB_STATE_OFS) begin
            rd_val[`GPB_STATE_HOLD_BIT] = r.hold_en;
            rd_val[`GPB_STATE_SLEEP_BIT] = r.sleep_oe_low & sleep_i;
        end
    end

    // ============================================================
    // Write-one-to-clear mask for pending flags
    always_comb begin
        stat_clr = '0;
        if (r.bus == BUS_WR && r.addr == `GPB_ISTAT_OFS) begin
            stat_clr = hwdata_i[NPIN-1:0];
        end
    end

    // ============================================================
    // Next state
    always_comb begin
        n = r;
        n.lvl = sif.lvl;

        // Data phase of a write; unmapped offsets are ignored
        if (r.bus == BUS_WR) begin
            if (r.addr == `GPB_OUT_OFS) begin
                n.out = hwdata_i[NPIN-1:0];
            end else if (r.addr == `GPB_OE_OFS) begin
                n.oe = hwdata_i[NPIN-1:0];
            end else if (r.addr == `GPB_PU_OFS) begin
                n.pu = hwdata_i[NPIN-1:0];
            end else if (r.addr == `GPB_PD_OFS) begin
                n.pd = hwdata_i[NPIN-1:0];
            end else if (r.addr == `GPB_FUNC0_OFS) begin
                n.func[31:0] = hwdata_i;
            end else if (r.addr == `GPB_FUNC1_OFS) begin
                n.func[2*NPIN-1:32] = hwdata_i[2*NPIN-33:0];
            end else if (r.addr == `GPB_ITYPE_OFS) begin
                n.itype = hwdata_i[NPIN-1:0];
            end else if (r.addr == `GPB_IPOL_OFS) begin
                n.ipol = hwdata_i[NPIN-1:0];
            end else if (r.addr == `GPB_IMASK_OFS) begin
                n.imask = hwdata_i[NPIN-1:0];
            end else if (r.addr == `GPB_HOLD_OFS) begin
                n.hold_en = hwdata_i[`GPB_HOLD_EN_BIT];
                n.sleep_oe_low = hwdata_i[`GPB_HOLD_SLEEP_BIT];
            end
        end

        // A hit in the clearing cycle keeps its flag set
        n.istat = (r.istat & ~stat_clr) | sif.hit;
        n.irq = |(n.istat & n.imask);

        // Frozen while holding, so pads ride through a low-power period
        if (!r.hold_en) begin
            n.pad_out = mux_out;
            n.pad_oe = mux_oe;
            n.pull_up = r.pu & ~r.pd;
            n.pull_dn = r.pd & ~r.pu;
        end
        if (r.sleep_oe_low && sleep_i) begin
            n.pad_oe = '0;
        end
        // Keeper only on pins nobody inside drives
        n.keep = {NPIN{r.hold_en}} & ~n.pad_oe;

        // Bus phases
        case (r.bus)
            BUS_RD: begin
                n.rdata = rd_val;
                n.readyout = 1'b1;
                n.bus = BUS_IDLE;
            end
            default: begin
                n.bus = BUS_IDLE;
                n.readyout = 1'b1;
                if (hsel_i && htrans_i[1] && hready_i) begin
                    n.addr = haddr_i[`GPB_ADDR_W-1:0];
                    if (hwrite_i) begin
                        n.bus = BUS_WR;
                    end else begin
                        n.bus = BUS_RD;
                        n.readyout = 1'b0;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            r <= '0;
            r.bus <= BUS_IDLE;
            r.readyout <= 1'b1;
            r.rdata <= `GPB_ZERO_RST;
        end else begin
            r <= n;
        end
    end

    // ============================================================
    // Outputs
    assign hrdata_o = r.rdata;
    assign hreadyout_o = r.readyout;
    assign hresp_o = 1'b0;
    assign pad_out_o = r.pad_out;
    assign pad_oe_o = r.pad_oe;
    assign pull_up_o = r.pull_up;
    assign pull_dn_o = r.pull_dn;
    assign keep_o = r.keep;
    assign pin_lvl_o = r.lvl;
    assign irq_o = r.irq;

endmodule : gpb_bank
`default_nettype wire

// *** verif/gpb_bank_checker.sv ***
// Purpose: Port-level checks of the pad bank
// Assumes: One clock, asynchronous active-high reset
// Notes:   Hold is seen only through keep_o
`timescale 1ns/1ps
`default_nettype none
module gpb_bank_checker #(
    parameter int NPIN = 17
) (
    // Clock, reset and bus
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic hready_i,
    input wire logic [31:0] hrdata_o,
    input wire logic hreadyout_o,
    input wire logic hresp_o,
    // Pads
    input wire logic [NPIN-1:0] pad_in_i,
    input wire logic [NPIN-1:0] pad_out_o,
    input wire logic [NPIN-1:0] pad_oe_o,
    input wire logic [NPIN-1:0] pull_up_o,
    input wire logic [NPIN-1:0] pull_dn_o,
    input wire logic [NPIN-1:0] keep_o,
    input wire logic [NPIN-1:0] pin_lvl_o
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);
    logic tk;
    logic [2:0] up_reg;
    assign tk = hsel_i && htrans_i[1] && hready_i;
    // Synchroniser still holds reset zeros in the first cycles
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            up_reg <= 3'h0;
        end else if (up_reg != 3'h7) begin
            up_reg <= up_reg + 3'h1;
        end
    end
    resp_okay_a: assert property (hresp_o == 1'b0) else $error("bad response");
    rd_wait_a: assert property (tk && !hwrite_i |=> !hreadyout_o ##1 hreadyout_o)
        else $error("read wait wrong");
    wr_nowait_a: assert property (tk && hwrite_i |=> hreadyout_o)
        else $error("write waited");
    unmapped_zero_a: assert property (tk && !hwrite_i && haddr_i[7:0] > 8'h33
        |-> ##2 hrdata_o == 32'h0000_0000) else $error("unmapped read not zero");
    pull_excl_a: assert property ((pull_up_o & pull_dn_o) == '0) else $error("both pulls");
    keep_undriven_a: assert property ((keep_o & pad_oe_o) == '0) else $error("keep on driven");
    hold_freeze_a: assert property ((|keep_o) && $past(|keep_o) |-> $stable(pad_out_o)
        && $stable(pull_up_o) && $stable(pull_dn_o)) else $error("held pad moved");
    lvl_follow_a: assert property ((up_reg == 3'h7 && $stable(pad_in_i)) [*4]
        |-> pin_lvl_o == pad_in_i) else $error("level not followed");
endmodule : gpb_bank_checker
bind gpb_bank gpb_bank_checker #(.NPIN(NPIN)) chk_u (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
    .hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i),
    .hready_i(hready_i), .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
    .pad_in_i(pad_in_i), .pad_out_o(pad_out_o), .pad_oe_o(pad_oe_o), .pull_up_o(pull_up_o),
    .pull_dn_o(pull_dn_o), .keep_o(keep_o), .pin_lvl_o(pin_lvl_o));
`default_nettype wire

// *** verif/gpb_pad_model.sv ***
// Purpose: External circuit and wire level on each pad
// Assumes: Pad driver wins when the bench also drives ext_* on the same pin
// Notes:   A floating pad toggles so no stale level passes
`timescale 1ns/1ps
`default_nettype none
module gpb_pad_model #(
    parameter int NPIN = 17
) (
    // Clock
    input wire logic clk_sys_i,
    // Pad controls
    input wire logic [NPIN-1:0] pad_out_i,
    input wire logic [NPIN-1:0] pad_oe_i,
    input wire logic [NPIN-1:0] pull_up_i,
    input wire logic [NPIN-1:0] pull_dn_i,
    input wire logic [NPIN-1:0] keep_i,
    // External driver
    input wire logic [NPIN-1:0] ext_en_i,
    input wire logic [NPIN-1:0] ext_val_i,
    output logic [NPIN-1:0] pad_lvl_o
);
    logic [NPIN-1:0] last_reg = '0;
    always_ff @(posedge clk_sys_i) last_reg <= pad_lvl_o;
    always_comb begin
        for (int i = 0; i < NPIN; i++) begin
            if (pad_oe_i[i]) pad_lvl_o[i] = pad_out_i[i];
            else if (ext_en_i[i]) pad_lvl_o[i] = ext_val_i[i];
            else if (pull_up_i[i] != pull_dn_i[i]) pad_lvl_o[i] = pull_up_i[i];
            else if (keep_i[i]) pad_lvl_o[i] = last_reg[i];
            else pad_lvl_o[i] = ~last_reg[i];
        end
    end
endmodule : gpb_pad_model
`default_nettype wire

// *** verif/gpb_bank_bench.sv ***
// Purpose: Self-checking bench of the pad bank
// Assumes: Single AHB-Lite master, one slave
// Notes:   Random data from a fixed xorshift seed
`timescale 1ns/1ps
`default_nettype none
`include "gpb_regs.svh"
module gpb_bank_bench;
    localparam logic [31:0] M = 32'h0001_FFFF;
    localparam logic [7:0] OFS [10] = '{`GPB_OUT_OFS, `GPB_OE_OFS, `GPB_PU_OFS, `GPB_PD_OFS,
        `GPB_FUNC0_OFS, `GPB_FUNC1_OFS, `GPB_ITYPE_OFS, `GPB_IPOL_OFS, `GPB_IMASK_OFS, `GPB_HOLD_OFS};
    localparam logic [31:0] MSK [10] = '{M, M, M, M, 32'hFFFF_FFFF, 32'h0000_0003, M, M, M,
        32'h0000_0003};
    logic clk_sys_i = 1'b0, rst_i = 1'b1, hsel_i = 1'b0, hwrite_i = 1'b0, sleep_i = 1'b0;
    logic [1:0] htrans_i = 2'h0;
    logic [31:0] haddr_i = '0, hwdata_i = '0, seed = 32'h0000_80a5, v, w, r;
    logic [50:0] alt_out_i = '0, alt_oe_i = '0;
    logic [16:0] ext_en = '0, ext_val = '0, pad_lvl, pad_out_o, pad_oe_o, pu, pd, keep, pin_lvl;
    logic [31:0] hrdata_o;
    logic hreadyout_o, irq_o;
    int n_mismatch = 0, samples_checked = 0, cyc = 0;
    always #12.5 clk_sys_i = ~clk_sys_i;
    gpb_bank dut_u (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
        .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(3'h2), .hwdata_i(hwdata_i),
        .hready_i(hreadyout_o), .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(),
        .alt_out_i(alt_out_i), .alt_oe_i(alt_oe_i), .sleep_i(sleep_i), .pad_in_i(pad_lvl),
        .pad_out_o(pad_out_o), .pad_oe_o(pad_oe_o), .pull_up_o(pu), .pull_dn_o(pd),
        .keep_o(keep), .pin_lvl_o(pin_lvl), .irq_o(irq_o));
    gpb_pad_model pad_u (.clk_sys_i(clk_sys_i), .pad_out_i(pad_out_o), .pad_oe_i(pad_oe_o),
        .pull_up_i(pu), .pull_dn_i(pd), .keep_i(keep), .ext_en_i(ext_en),
        .ext_val_i(ext_val), .pad_lvl_o(pad_lvl));
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    // Pull resolves only when exactly one side is enabled
    function automatic logic [31:0] pull_exp(input logic [31:0] a, input logic [31:0] b);
        return a & ~b & M;
    endfunction : pull_exp
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : end_of_test
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // hready and read data are taken at the rising edge, before the slave's update lands
    task automatic wait_rdy(output logic [31:0] d);
        do @(posedge clk_sys_i); while (hreadyout_o !== 1'b1);
        d = hrdata_o;
    endtask : wait_rdy
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys_i);
        hsel_i <= 1'b1;
        haddr_i <= {24'h00_0000, a};
        htrans_i <= 2'h2;
        hwrite_i <= wr;
        wait_rdy(r);
        hsel_i <= 1'b0;
        htrans_i <= 2'h0;
        hwdata_i <= d;
        wait_rdy(r);
    endtask : xfer
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask : wr
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0000_0000);
        chk(r, exp);
    endtask : rd_chk
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys_i);
    endtask : tick
    always @(posedge clk_sys_i) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_mismatch++;
            end_of_test();
        end
    end
    initial begin
        tick(2);
        rst_i <= 1'b0;
        ext_en <= 17'h1_FFFF;
        ext_val <= 17'h0_A5C3;
        foreach (OFS[i]) rd_chk(OFS[i], 32'h0000_0000);
        rd_chk(8'h34, 32'h0000_0000);
        rd_chk(`GPB_IN_OFS, 32'h0000_A5C3);
        wr(`GPB_IN_OFS, rnd());
        rd_chk(`GPB_IN_OFS, 32'h0000_A5C3);
        for (int k = 0; k < 3; k++) foreach (OFS[i]) begin
            v = rnd() & MSK[i];
            wr(OFS[i], v);
            rd_chk(OFS[i], v);
        end
        foreach (OFS[i]) wr(OFS[i], 32'h0000_0000);
        v = rnd() & M;
        wr(`GPB_OE_OFS, M);
        wr(`GPB_OUT_OFS, v);
        tick(4);
        chk(32'(pad_out_o), v);
        chk(32'(pad_oe_o), M);
        rd_chk(`GPB_IN_OFS, v);
        chk(32'(pin_lvl), v);
        wr(`GPB_OE_OFS, 32'h0000_0000);
        ext_en <= '0;
        v = rnd();
        w = rnd();
        wr(`GPB_PU_OFS, v & M);
        wr(`GPB_PD_OFS, w & M);
        tick(3);
        chk(32'(pu), pull_exp(v, w));
        chk(32'(pd), pull_exp(w, v));
        for (int f = 1; f < 4; f++) begin
            alt_out_i <= 51'({rnd(), rnd()});
            alt_oe_i <= 51'({rnd(), rnd()});
            wr(`GPB_FUNC0_OFS, {16{2'(f)}});
            wr(`GPB_FUNC1_OFS, 32'(f));
            tick(3);
            chk(32'(pad_out_o), 32'(alt_out_i[(f-1)*17 +: 17]));
            chk(32'(pad_oe_o), 32'(alt_oe_i[(f-1)*17 +: 17]));
        end
        wr(`GPB_FUNC0_OFS, 32'h0000_0000);
        wr(`GPB_FUNC1_OFS, 32'h0000_0000);
        ext_en <= 17'h1_FFFF;
        ext_val <= '0;
        wr(`GPB_ITYPE_OFS, M);
        wr(`GPB_IPOL_OFS, M);
        tick(6);
        wr(`GPB_ISTAT_OFS, M);
        v = (rnd() & M) | 32'h0000_0001;
        ext_val <= v[16:0];
        tick(8);
        rd_chk(`GPB_ISTAT_OFS, v);
        chk(32'(irq_o), 32'h0000_0000);
        wr(`GPB_IMASK_OFS, v);
        tick(3);
        chk(32'(irq_o), 32'h0000_0001);
        wr(`GPB_ISTAT_OFS, v);
        tick(3);
        chk(32'(irq_o), 32'h0000_0000);
        rd_chk(`GPB_ISTAT_OFS, 32'h0000_0000);
        wr(`GPB_ITYPE_OFS, 32'h0000_0000);
        tick(2);
        wr(`GPB_ISTAT_OFS, M);
        rd_chk(`GPB_ISTAT_OFS, v);
        chk(32'(irq_o), 32'h0000_0001);
        // Falling-edge mode: only the pins that were high may flag
        wr(`GPB_ITYPE_OFS, M);
        wr(`GPB_IPOL_OFS, 32'h0000_0000);
        wr(`GPB_ISTAT_OFS, M);
        ext_val <= '0;
        tick(8);
        rd_chk(`GPB_ISTAT_OFS, v);
        wr(`GPB_IMASK_OFS, 32'h0000_0000);
        ext_en <= '0;
        wr(`GPB_OUT_OFS, v);
        wr(`GPB_OE_OFS, v);
        wr(`GPB_HOLD_OFS, 32'h0000_0001);
        tick(3);
        wr(`GPB_OUT_OFS, ~v & M);
        tick(3);
        chk(32'(pad_out_o), v);
        chk(32'(keep), ~v & M);
        wr(`GPB_HOLD_OFS, 32'h0000_0003);
        sleep_i <= 1'b1;
        tick(3);
        chk(32'(pad_oe_o), 32'h0000_0000);
        rd_chk(`GPB_STATE_OFS, 32'h0000_0003);
        sleep_i <= 1'b0;
        wr(`GPB_HOLD_OFS, 32'h0000_0000);
        // Reset again in mid-run; OUT still holds a nonzero value here
        rst_i <= 1'b1;
        tick(2);
        rst_i <= 1'b0;
        tick(1);
        chk(32'(hreadyout_o), 32'h0000_0001);
        chk(32'(pad_oe_o), 32'h0000_0000);
        chk(32'(keep), 32'h0000_0000);
        rd_chk(`GPB_OUT_OFS, 32'h0000_0000);
        end_of_test();
    end
endmodule : gpb_bank_bench
`default_nettype wire
